// file: src/led_ctrl_pkg.sv
/*
 * Shared constants, field layouts and carriers of the LED channel control
 * register bank. Assumes a 100 MHz clock and 16-bit control words that
 * carry their own address in the top nibble.
 */
package led_ctrl_pkg;

   // Word layout
   localparam int WORD_W = 16;
   localparam int ADDR_HI = 15;
   localparam int ADDR_LO = 12;
   localparam int WD_BIT = 11;
   localparam int DATA_HI = 10;
   localparam int NUM_CH = 8;
   localparam int CH_IDX_W = 3;

   // Register addresses
   localparam logic [3:0] ADDR_CH_FIRST = 4'h1;
   localparam logic [3:0] ADDR_CH_LAST = 4'h8;
   localparam logic [3:0] ADDR_MODE = 4'h9;
   localparam logic [3:0] ADDR_OUTEN = 4'hA;
   localparam logic [3:0] ADDR_SEL12 = 4'hB;

   // Writable data bits per register (address and watchdog bit excluded)
   localparam logic [10:0] MASK_CH = 11'h7FF;
   localparam logic [10:0] MASK_MODE = 11'h1FF;
   localparam logic [10:0] MASK_OUTEN = 11'h0FF;
   localparam logic [10:0] MASK_SEL = 11'h0FF;

   // Reset values, full words for the shared registers and data part only for the channels
   localparam logic [15:0] RST_MODE = 16'h9000;
   localparam logic [15:0] RST_OUTEN = 16'hA001;
   localparam logic [15:0] RST_SEL = 16'hB000;
   localparam logic [10:0] RST_CH_DATA = 11'h000;
   localparam logic [10:0] DATA_ZERO = 11'h000;

   // Field positions
   localparam int OC_BLANK_DISABLE_BIT = 8;
   localparam int SEL_CH2_IN_LO = 6;
   localparam int SEL_CH2_PWM_LO = 4;
   localparam int SEL_CH1_IN_LO = 2;
   localparam int SEL_CH1_PWM_LO = 0;

   // Timing
   localparam longint CLK_HZ = 100_000_000;
   localparam longint WD_PERIOD_MS = 75;
   localparam longint BLANK_US = 150;
   localparam int WD_CYCLES = int'((CLK_HZ / 1000) * WD_PERIOD_MS);
   localparam int BLANK_CYCLES = int'((CLK_HZ / 1_000_000) * BLANK_US);
   localparam int WD_CNT_W = 24;
   localparam int BLANK_CNT_W = 16;

   typedef enum logic [1:0] {
      PHASE_0DEG = 2'h0,
      PHASE_90DEG = 2'h1,
      PHASE_180DEG = 2'h2,
      PHASE_270DEG = 2'h3
   } phase_e;

   typedef struct packed {
      phase_e phaseSelect;
      logic pulseSkipEnable;
      logic [7:0] channelDuty;
   } chan_cfg_s;

   typedef struct packed {
      logic [1:0] directInputFunction;
      logic [1:0] pwmSourceFunction;
   } chan_sel_s;

   // True for the eight per-channel control addresses
   function automatic logic isChanAddr(input logic [3:0] a);
      return (a >= ADDR_CH_FIRST) && (a <= ADDR_CH_LAST);
   endfunction : isChanAddr

   // Channel index 0..7 from a channel address
   function automatic logic [2:0] chanIdx(input logic [3:0] a);
      logic [3:0] t;
      t = a - ADDR_CH_FIRST;
      return t[2:0];
   endfunction : chanIdx

endpackage : led_ctrl_pkg

// file: src/chan_word_store.sv
/*
 * Storage of the eight channel control words with parallel outputs for the
 * PWM logic and a registered readback port. Assumes write and read
 * strobes come from logic on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none

module chan_word_store
   import led_ctrl_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic wrEn,
   input wire logic [CH_IDX_W-1:0] wrIdx,
   input wire chan_cfg_s wrData,
   input wire logic rdEn,
   input wire logic [CH_IDX_W-1:0] rdIdx,
   output chan_cfg_s cfg [NUM_CH],
   output chan_cfg_s rdData
);

   chan_cfg_s word_q [NUM_CH];
   chan_cfg_s word_d [NUM_CH];
   chan_cfg_s rdData_q;
   chan_cfg_s rdData_d;

   // One word per channel, written only when its index matches
   for (genvar i = 0; i < NUM_CH; i++) begin : g_word
      always_comb begin
         word_d[i] = word_q[i];
         if (wrEn && (wrIdx == CH_IDX_W'(i))) begin
            word_d[i] = wrData;
         end
      end

      always_ff @(posedge clk) begin
         if (srst) begin
            word_q[i] <= chan_cfg_s'(RST_CH_DATA);
         end else begin
            word_q[i] <= word_d[i];
         end
      end

      assign cfg[i] = word_q[i];
   end

   // Readback holds its last value between requests
   always_comb begin
      rdData_d = rdData_q;
      if (rdEn) begin
         rdData_d = word_q[rdIdx];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rdData_q <= chan_cfg_s'(RST_CH_DATA);
      end else begin
         rdData_q <= rdData_d;
      end
   end

   assign rdData = rdData_q;

endmodule : chan_word_store

`default_nettype wire

// file: src/led_channel_control_registers.sv
/*
 * Control register bank of an eight-channel LED driver: channel words,
 * mode, output enables and channel 1/2 source selectors, plus the
 * watchdog toggle check and overcurrent blanking timers.
 * Assumes the serial front end hands over each validated 16-bit word as a
 * one-cycle strobe on this clock and asks for readback the same way.
 */
`timescale 1ns/1ns
`default_nettype none

module led_channel_control_registers
   import led_ctrl_pkg::*;
#(
   parameter int WdCycles = WD_CYCLES,
   parameter int BlankCycles = BLANK_CYCLES
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic wrValid,
   input wire logic [WORD_W-1:0] wrWord,
   input wire logic rdReq,
   input wire logic [3:0] rdAddr,
   output logic rdValid,
   output logic [WORD_W-1:0] rdWord,
   output chan_cfg_s chanCfg [NUM_CH],
   output logic ocBlankDisable,
   output logic [NUM_CH-1:0] currentLimitSelect,
   output logic [NUM_CH-1:0] outputOn,
   output chan_sel_s ch1Select,
   output chan_sel_s ch2Select,
   output logic [NUM_CH-1:0] ocBlankActive,
   output logic watchdogToggle,
   output logic wdMismatch,
   output logic wdExpired
);

   // Terminal counts taken from the parameters
   localparam logic [WD_CNT_W-1:0] WD_LAST = WD_CNT_W'(WdCycles - 1);
   localparam logic [BLANK_CNT_W-1:0] BLANK_LOAD = BLANK_CNT_W'(BlankCycles);

   logic [3:0] wrAddr;
   logic [10:0] wrData;
   logic goodToggle;

   // Watchdog state and timeout counter, declared ahead of the toggle check
   logic watchdogToggle_q;
   logic watchdogToggle_d;
   logic [WD_CNT_W-1:0] wdCnt_q;
   logic [WD_CNT_W-1:0] wdCnt_d;
   logic wdExpired_q;
   logic wdExpired_d;
   logic wdMismatch_q;
   logic wdMismatch_d;
   logic wdHit;
   logic wdAtLast;

   // Address and data fields of the incoming word
   assign wrAddr = wrWord[ADDR_HI:ADDR_LO];
   assign wrData = wrWord[DATA_HI:0];
   assign goodToggle = wrValid && (wrWord[WD_BIT] != watchdogToggle_q);

   // Shared registers
   logic [10:0] mode_q;
   logic [10:0] mode_d;
   logic [10:0] outEn_q;
   logic [10:0] outEn_d;
   logic [10:0] sel_q;
   logic [10:0] sel_d;

   // Reserved bits masked off, stay zero whatever the host sends
   always_comb begin
      mode_d = mode_q;
      outEn_d = outEn_q;
      sel_d = sel_q;
      if (wrValid) begin
         case (wrAddr)
            // Blank disable and limit bits stored
            ADDR_MODE: begin
               mode_d = wrData & MASK_MODE;
            end
            ADDR_OUTEN: begin
               outEn_d = wrData & MASK_OUTEN;
            end
            ADDR_SEL12: begin
               sel_d = wrData & MASK_SEL;
            end
            default: begin
               mode_d = mode_q;
            end
         endcase
      end
   end

   // Reset loads the data part of each documented reset word
   always_ff @(posedge clk) begin
      if (srst) begin
         mode_q <= RST_MODE[DATA_HI:0];
         outEn_q <= RST_OUTEN[DATA_HI:0];
         sel_q <= RST_SEL[DATA_HI:0];
      end else begin
         mode_q <= mode_d;
         outEn_q <= outEn_d;
         sel_q <= sel_d;
      end
   end

   // Register fields go straight to the outputs
   assign ocBlankDisable = mode_q[OC_BLANK_DISABLE_BIT];
   // One limit select bit per channel
   assign currentLimitSelect = mode_q[NUM_CH-1:0];
   assign outputOn = outEn_q[NUM_CH-1:0];
   // Direct input selectors for channels 2 and 1
   assign ch2Select.directInputFunction = sel_q[SEL_CH2_IN_LO +: 2];
   assign ch1Select.directInputFunction = sel_q[SEL_CH1_IN_LO +: 2];
   // PWM source selectors for channels 2 and 1
   assign ch2Select.pwmSourceFunction = sel_q[SEL_CH2_PWM_LO +: 2];
   assign ch1Select.pwmSourceFunction = sel_q[SEL_CH1_PWM_LO +: 2];

   // Channel words live in the store; readback comes out registered
   chan_cfg_s chanRd;
   logic chanWr;

   // Addresses 1..8 decode to the channel store
   assign chanWr = wrValid && isChanAddr(wrAddr);

   // Phase, skip and duty fields kept as one word
   chan_word_store u_store (
      .clk(clk),
      .srst(srst),
      .wrEn(chanWr),
      .wrIdx(chanIdx(wrAddr)),
      .wrData(chan_cfg_s'(wrData & MASK_CH)),
      .rdEn(rdReq && isChanAddr(rdAddr)),
      .rdIdx(chanIdx(rdAddr)),
      .cfg(chanCfg),
      .rdData(chanRd)
   );

   // A timeout in the same cycle as a good toggle still sets
   always_comb begin
      watchdogToggle_d = watchdogToggle_q;
      wdCnt_d = wdCnt_q;
      wdExpired_d = wdExpired_q;
      wdMismatch_d = wrValid && !goodToggle;
      // Counter parks at its last value while no good toggle comes
      wdAtLast = (wdCnt_q == WD_LAST);
      // Only the first arrival is an expiry event, so a parked counter
      // does not block the clear by the next good toggle
      wdHit = wdAtLast && !wdExpired_q;
      if (goodToggle) begin
         watchdogToggle_d = !watchdogToggle_q;
         wdCnt_d = '0;
         wdExpired_d = 1'b0;
      end else if (!wdAtLast) begin
         wdCnt_d = wdCnt_q + 1'b1;
      end
      if (wdHit) begin
         wdExpired_d = 1'b1;
      end
   end

   // Watchdog registers
   always_ff @(posedge clk) begin
      if (srst) begin
         watchdogToggle_q <= 1'b0;
         wdCnt_q <= '0;
         wdExpired_q <= 1'b0;
         wdMismatch_q <= 1'b0;
      end else begin
         watchdogToggle_q <= watchdogToggle_d;
         wdCnt_q <= wdCnt_d;
         wdExpired_q <= wdExpired_d;
         wdMismatch_q <= wdMismatch_d;
      end
   end

   // Watchdog outputs
   assign watchdogToggle = watchdogToggle_q;
   assign wdExpired = wdExpired_q;
   assign wdMismatch = wdMismatch_q;

   // Overcurrent blanking, one timer per channel
   logic [NUM_CH-1:0] outPrev_q;
   logic [NUM_CH-1:0] blank_q;
   logic [NUM_CH-1:0] blank_d;
   logic [BLANK_CNT_W-1:0] blankCnt_q [NUM_CH];
   logic [BLANK_CNT_W-1:0] blankCnt_d [NUM_CH];

   // The trigger is the enable bit rising, not activity at the output pin
   for (genvar i = 0; i < NUM_CH; i++) begin : g_blank
      // Restart on switch-on; cut short if disabled or switched off
      always_comb begin
         blankCnt_d[i] = blankCnt_q[i];
         if (ocBlankDisable || !outputOn[i]) begin
            blankCnt_d[i] = '0;
         end else if (!outPrev_q[i]) begin
            blankCnt_d[i] = BLANK_LOAD;
         end else if (blankCnt_q[i] != '0) begin
            blankCnt_d[i] = blankCnt_q[i] - 1'b1;
         end
         blank_d[i] = (blankCnt_d[i] != '0);
      end

      // Counter register per channel
      always_ff @(posedge clk) begin
         if (srst) begin
            blankCnt_q[i] <= '0;
         end else begin
            blankCnt_q[i] <= blankCnt_d[i];
         end
      end
   end

   // Edge reference resets low, so channel 1 blanks right after reset
   always_ff @(posedge clk) begin
      if (srst) begin
         outPrev_q <= '0;
         blank_q <= '0;
      end else begin
         outPrev_q <= outputOn;
         blank_q <= blank_d;
      end
   end

   assign ocBlankActive = blank_q;

   // Readback pipeline: store answers one cycle later, word formed next
   logic rdPend_q;
   logic [3:0] rdAddrP_q;
   logic rdValid_q;
   logic rdValid_d;
   logic [WORD_W-1:0] rdWord_q;
   logic [WORD_W-1:0] rdWord_d;
   logic [10:0] rdBody;

   // Address nibble is constant per register, never writable
   always_comb begin
      rdBody = DATA_ZERO;
      if (isChanAddr(rdAddrP_q)) begin
         rdBody = 11'(chanRd);
      end else begin
         case (rdAddrP_q)
            ADDR_MODE: begin
               rdBody = mode_q;
            end
            ADDR_OUTEN: begin
               rdBody = outEn_q;
            end
            ADDR_SEL12: begin
               rdBody = sel_q;
            end
            default: begin
               rdBody = DATA_ZERO;
            end
         endcase
      end
      // Address nibble and toggle state are not stored per register
      rdValid_d = rdPend_q;
      rdWord_d = rdWord_q;
      if (rdPend_q) begin
         rdWord_d = {rdAddrP_q, watchdogToggle_q, rdBody};
      end
   end

   // rdAddrP_q follows rdAddr every cycle; only rdPend_q qualifies it
   always_ff @(posedge clk) begin
      if (srst) begin
         rdPend_q <= 1'b0;
         rdAddrP_q <= '0;
         rdValid_q <= 1'b0;
         rdWord_q <= '0;
      end else begin
         rdPend_q <= rdReq;
         rdAddrP_q <= rdAddr;
         rdValid_q <= rdValid_d;
         rdWord_q <= rdWord_d;
      end
   end

   // Readback outputs
   assign rdValid = rdValid_q;
   assign rdWord = rdWord_q;

endmodule : led_channel_control_registers

`default_nettype wire

// file: sim/led_regs_sva.sv
/* Port checker of the LED register bank.
   Assumes it is bound onto the bank top and shares its clock. */
`timescale 1ns/1ns
`default_nettype none
module led_regs_sva
   import led_ctrl_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic wrValid,
   input wire logic [WORD_W-1:0] wrWord,
   input wire logic rdReq,
   input wire logic [3:0] rdAddr,
   input wire logic rdValid,
   input wire logic [WORD_W-1:0] rdWord,
   input wire chan_cfg_s chanCfg [NUM_CH],
   input wire logic ocBlankDisable,
   input wire logic [NUM_CH-1:0] currentLimitSelect,
   input wire logic [NUM_CH-1:0] outputOn,
   input wire chan_sel_s ch1Select,
   input wire chan_sel_s ch2Select,
   input wire logic [NUM_CH-1:0] ocBlankActive,
   input wire logic watchdogToggle,
   input wire logic wdMismatch
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   logic [3:0] wa;
   logic good;
   // Target address and toggle quality of a write
   assign wa = wrWord[15:12];
   assign good = wrValid && (wrWord[11] != watchdogToggle);
   for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      AST_CH_WR:
      assert property (wrValid && wa == 4'(i + 1) |=>
         chanCfg[i] == chan_cfg_s'($past(wrWord[10:0]))) else $error("chan");
   end
   AST_MODE_WR:
   assert property (wrValid && wa == ADDR_MODE |=> ocBlankDisable ==
      $past(wrWord[8]) && currentLimitSelect == $past(wrWord[7:0]))
      else $error("mode");
   AST_OUTEN_WR:
   assert property (wrValid && wa == ADDR_OUTEN |=>
      outputOn == $past(wrWord[7:0])) else $error("outen");
   AST_SEL_WR:
   assert property (wrValid && wa == ADDR_SEL12 |=>
      ch1Select == $past(wrWord[3:0]) && ch2Select == $past(wrWord[7:4]))
      else $error("sel");
   // Pipelined reads allowed: each answer pairs with the request two back
   AST_RD_LAT:
   assert property (rdValid == $past(rdReq, 2))
      else $error("read latency");
   AST_RD_ADDR:
   assert property (rdReq |-> ##2 rdWord[15:12] == $past(rdAddr, 2))
      else $error("read address");
   AST_WD_GOOD:
   assert property (good |=> watchdogToggle == $past(wrWord[11]) &&
      !wdMismatch) else $error("toggle");
   AST_WD_BAD:
   assert property (wrValid && !good |=> wdMismatch && $stable(watchdogToggle))
      else $error("stale toggle");
   AST_BLANK_OFF:
   assert property (ocBlankDisable |=> ocBlankActive == 8'h00)
      else $error("blank off");
   AST_BLANK_LEN:
   assert property ($rose(ocBlankActive[1]) |->
      (ocBlankActive[1] || !outputOn[1])[*8]) else $error("blank short");
   // Main scenarios reached
   cover property (rdValid);
   cover property (wdMismatch);
   cover property ($rose(ocBlankActive[1]));
endmodule : led_regs_sva
bind led_channel_control_registers led_regs_sva u_sva (.clk(clk),
   .srst(srst), .wrValid(wrValid), .wrWord(wrWord), .rdReq(rdReq),
   .rdAddr(rdAddr), .rdValid(rdValid), .rdWord(rdWord), .chanCfg(chanCfg),
   .ocBlankDisable(ocBlankDisable), .currentLimitSelect(currentLimitSelect),
   .outputOn(outputOn), .ch1Select(ch1Select), .ch2Select(ch2Select),
   .ocBlankActive(ocBlankActive), .watchdogToggle(watchdogToggle),
   .wdMismatch(wdMismatch));
`default_nettype wire

// file: sim/host_model.sv
/* Host side model issuing control words and readbacks.
   Assumes the bench calls its tasks; drives on falling edges. */
`timescale 1ns/1ns
`default_nettype none
module host_model
   import led_ctrl_pkg::*;
(
   input wire logic clk,
   input wire logic rdValid,
   input wire logic [WORD_W-1:0] rdWord,
   output logic wrValid,
   output logic [WORD_W-1:0] wrWord,
   output logic rdReq,
   output logic [3:0] rdAddr
);
   logic tgl = 1'b0; // Toggle of the last good write
   initial begin
      wrValid = 1'b0;
      wrWord = 16'h0000;
      rdReq = 1'b0;
      rdAddr = 4'h0;
   end
   task automatic wr(input logic [3:0] a, input logic [10:0] d,
      input logic bad);
      logic [WORD_W-1:0] word;
      // Word built first so the port is assigned once per time step
      word = {a, bad ? tgl : ~tgl, a <= 4'h8 ? d : d & 11'h1FF};
      if (a > 4'h9) word[8] = 1'b0;
      @(negedge clk);
      wrValid = 1'b1;
      wrWord = word;
      if (!bad) tgl = ~tgl;
      @(negedge clk);
      wrValid = 1'b0;
      wrWord = ~wrWord; // Word lines do not hold after the strobe
   endtask : wr
   // Readback answer is awaited for a few cycles only
   task automatic rd(input logic [3:0] a, output logic [WORD_W-1:0] w);
      int n;
      @(negedge clk);
      rdReq = 1'b1;
      rdAddr = a;
      @(negedge clk);
      rdReq = 1'b0;
      rdAddr = ~a;
      n = 0;
      while (!rdValid && n < 4) begin
         @(negedge clk);
         n++;
      end
      w = rdValid ? rdWord : 16'hXXXX;
   endtask : rd
endmodule : host_model
`default_nettype wire

// file: sim/led_channel_control_registers_tb.sv
/* Self-checking bench of the LED channel control register bank.
   Assumes the host model drives the word port; counts are shortened. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin badCount++; \
   $display("MISMATCH %0t value differs", $time); end end
module led_channel_control_registers_tb
   import led_ctrl_pkg::*;
;
   localparam int WdT = 40;
   localparam int BlkT = 10;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic wrValid, rdReq, rdValid, ocBlankDisable, watchdogToggle;
   logic wdMismatch, wdExpired;
   logic [15:0] wrWord, rdWord, w;
   logic [3:0] rdAddr;
   logic [7:0] currentLimitSelect, outputOn, ocBlankActive;
   chan_cfg_s chanCfg [NUM_CH];
   chan_sel_s ch1Select, ch2Select;
   int badCount = 0;
   int compares = 0;
   int cyc = 0;
   always #5 clk = ~clk;
   led_channel_control_registers #(.WdCycles(WdT), .BlankCycles(BlkT)) u_dut (
      .clk(clk), .srst(srst), .wrValid(wrValid), .wrWord(wrWord),
      .rdReq(rdReq), .rdAddr(rdAddr), .rdValid(rdValid), .rdWord(rdWord),
      .chanCfg(chanCfg), .ocBlankDisable(ocBlankDisable),
      .currentLimitSelect(currentLimitSelect), .outputOn(outputOn),
      .ch1Select(ch1Select), .ch2Select(ch2Select),
      .ocBlankActive(ocBlankActive), .watchdogToggle(watchdogToggle),
      .wdMismatch(wdMismatch), .wdExpired(wdExpired));
   host_model u_host (.clk(clk), .rdValid(rdValid), .rdWord(rdWord),
      .wrValid(wrValid), .wrWord(wrWord), .rdReq(rdReq), .rdAddr(rdAddr));
   task automatic summarize();
      $display("compares %0d mismatches %0d", compares, badCount);
      if (badCount == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : summarize
   // Cut a hang short
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         badCount++;
         summarize();
      end
   end
   // Reset words, channel 1 blanking out of reset, unmapped address
   task automatic testReset();
      @(negedge clk);
      `CHK(ocBlankActive, 8'h01)
      u_host.rd(ADDR_MODE, w);
      `CHK(w, 16'h9000)
      u_host.rd(ADDR_OUTEN, w);
      `CHK(w, 16'hA001)
      u_host.rd(ADDR_SEL12, w);
      `CHK(w, 16'hB000)
      u_host.rd(4'h0, w);
      `CHK(w, 16'h0000)
   endtask : testReset
   // All phase codes, skip on and off, duty 0x00 to 0xFF
   task automatic testChannels();
      logic [10:0] d;
      for (int i = 1; i <= 8; i++) begin
         d = {2'(i), i[0], i == 8 ? 8'hFF : 8'(i * 32 - 32)};
         u_host.wr(4'(i), d, 1'b0);
         `CHK(chanCfg[i-1], chan_cfg_s'(d))
         u_host.rd(4'(i), w);
         `CHK(w, {4'(i), u_host.tgl, d})
      end
   endtask : testChannels
   // Mode, enables and selectors with blanking disabled
   task automatic testModeSel();
      u_host.wr(ADDR_MODE, 11'h5A5, 1'b0);
      `CHK(ocBlankDisable, 1'b1)
      `CHK(currentLimitSelect, 8'hA5)
      u_host.wr(ADDR_OUTEN, 11'h0F0, 1'b0);
      `CHK(outputOn, 8'hF0)
      @(negedge clk);
      `CHK(ocBlankActive, 8'h00)
      u_host.wr(ADDR_SEL12, 11'h0E4, 1'b0);
      `CHK(ch1Select, chan_sel_s'(4'h4))
      `CHK(ch2Select, chan_sel_s'(4'hE))
      u_host.rd(ADDR_SEL12, w);
      `CHK(w, {4'hB, u_host.tgl, 11'h0E4})
      // Unmapped address stores nothing
      u_host.wr(4'hC, 11'h011, 1'b0);
      u_host.rd(ADDR_SEL12, w);
      `CHK(w, {4'hB, u_host.tgl, 11'h0E4})
   endtask : testModeSel
   // Blank window length after channel 2 switches on
   task automatic testBlank();
      u_host.wr(ADDR_MODE, 11'h000, 1'b0);
      u_host.wr(ADDR_OUTEN, 11'h0F2, 1'b0);
      @(negedge clk);
      `CHK(ocBlankActive, 8'h02)
      // Last blanked cycle, then the first clear one
      repeat (BlkT - 1) @(negedge clk);
      `CHK(ocBlankActive, 8'h02)
      @(negedge clk);
      `CHK(ocBlankActive, 8'h00)
   endtask : testBlank
   // Stale toggle, expiry and recovery
   task automatic testWatchdog();
      u_host.wr(4'h1, 11'h000, 1'b1);
      `CHK(wdMismatch, 1'b1)
      `CHK(watchdogToggle, u_host.tgl)
      repeat (WdT + 2) @(negedge clk);
      `CHK(wdExpired, 1'b1)
      u_host.wr(4'h1, 11'h000, 1'b0);
      `CHK(wdExpired, 1'b0)
      // Expiry lands exactly WdT cycles after the good toggle
      repeat (WdT - 1) @(negedge clk);
      `CHK(wdExpired, 1'b0)
      @(negedge clk);
      `CHK(wdExpired, 1'b1)
   endtask : testWatchdog
   // Main sequence
   initial begin
      repeat (6) @(negedge clk);
      srst = 1'b0;
      testReset();
      testChannels();
      testModeSel();
      testBlank();
      testWatchdog();
      summarize();
   end
endmodule : led_channel_control_registers_tb
`default_nettype wire
